/* File: prs_map.vh */
`ifndef PRS_MAP_VH
`define PRS_MAP_VH
// Sensor geometry with one-based coordinates.
`define PRS_COLS        12'd2352
`define PRS_ROWS        11'd1728
`define PRS_FIRST_COL   12'd1
`define PRS_FIRST_ROW   11'd1
// Tap arrangements.
`define PRS_TAPS_FOUR   3'd4
`define PRS_TAPS_TWO    3'd2
// Pixel data width and output buffer geometry.
`define PRS_PIX_W       10
`define PRS_WORD_W      28
`define PRS_FIFO_DEPTH  16
`define PRS_FIFO_AW     4
// Field positions inside the buffer word; bits 12 to 10 are spare and zero.
`define PRS_W_END       27
`define PRS_W_TAP_HI    26
`define PRS_W_TAP_LO    24
`define PRS_W_ROW_HI    23
`define PRS_W_ROW_LO    13
`define PRS_W_PIX_HI    9
`endif

/* File: prs_sequencer.v */
`timescale 1ns/1ps
`include "prs_map.vh"

module prs_fifo #(
  parameter WIDTH = 28,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_in,     // Clock.
  input  wire             rst_b_in,   // Synchronised active-low reset.
  input  wire             wr_valid_in, // Write data valid.
  output wire             wr_ready_out, // Space available.
  input  wire [WIDTH-1:0] wr_data_in, // Write data.
  output wire             rd_valid_out, // Data available.
  input  wire             rd_ready_in, // Reader accepts.
  output wire [WIDTH-1:0] rd_data_out // Read data.
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            do_wr;
  wire            do_rd;

  // Handshakes and honest full and empty flags.
  assign wr_ready_out = (cnt_r != DEPTH);
  assign rd_valid_out = (cnt_r != {(AW+1){1'b0}});
  assign do_wr        = wr_valid_in & wr_ready_out;
  assign do_rd        = rd_valid_out & rd_ready_in;
  assign rd_data_out  = mem_r[rp_r];

  // Storage is written at the write index.
  always @(posedge clk_in) begin
    if (do_wr) begin
      mem_r[wp_r] <= wr_data_in;
    end
  end

  // Pointers and occupancy count.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_rd) begin
        rp_r <= rp_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

module prs_sequencer (
  input  wire        CLOCK_IN,        // Pixel clock, 40 MHz.
  input  wire        RST_B_IN,        // Asynchronous active-low reset.
  input  wire        FRAME_START_IN,  // Pin: request a new frame.
  input  wire        TWO_TAP_IN,      // Pin: 1 selects two-tap, 0 four-tap.
  input  wire [9:0]  PIX_DATA_IN,     // Pixel value for the addressed site.
  output reg  [11:0] PIX_COL_OUT,     // Column address to the array.
  output reg  [10:0] PIX_ROW_OUT,     // Row address to the array.
  output reg         OUT_VALID_OUT,   // Output word valid.
  input  wire        OUT_READY_IN,    // Grabber side accepts.
  output reg  [11:0] OUT_COL_OUT,     // Column of output pixel.
  output reg  [10:0] OUT_ROW_OUT,     // Row of output pixel.
  output reg  [2:0]  OUT_TAP_OUT,     // Tap number, one based.
  output reg  [9:0]  OUT_PIX_OUT,     // Pixel value.
  output reg         OUT_FRAME_END_OUT, // Last pixel of frame.
  output reg         BUSY_OUT         // Frame readout in progress.
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SCAN = 1'b1;

  reg [1:0]  rst_sync_r;
  wire       rst_b;
  reg [2:0]  fs_sync_r;
  reg [2:0]  tt_sync_r;
  reg        fs_lvl_r;
  reg        fs_prev_r;
  reg        tt_lvl_r;
  reg        state_r;
  reg        state_nxt;
  reg [11:0] col_r;
  reg [11:0] col_nxt;
  reg [10:0] row_r;
  reg [10:0] row_nxt;
  reg        two_tap_r;
  wire       fs_rise;
  wire       last_col;
  wire       last_pix;
  wire       push;
  wire       fifo_ready;
  wire       fifo_valid;
  wire [27:0] wdata;
  wire [27:0] rdata;
  wire       take;

  // Tap for a one-based column in four- or two-tap mode.
  function [2:0] tap_of;
    input [11:0] col;
    input        two;
    reg   [11:0] c0;
    begin
      c0 = col - `PRS_FIRST_COL;
      if (two) begin
        tap_of = {2'b00, c0[0]} + 3'd1;
      end else begin
        tap_of = {1'b0, c0[1:0]} + 3'd1;
      end
    end
  endfunction

  // Reset release through two flip-flops.
  always @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_r[1];

  // Pin inputs pass three flip-flops; a change counts when stages two and three agree.
  always @(posedge CLOCK_IN or negedge rst_b) begin
    if (!rst_b) begin
      fs_sync_r <= 3'b000;
      tt_sync_r <= 3'b000;
      fs_lvl_r  <= 1'b0;
      tt_lvl_r  <= 1'b0;
      fs_prev_r <= 1'b0;
    end else begin
      fs_sync_r <= {fs_sync_r[1:0], FRAME_START_IN};
      tt_sync_r <= {tt_sync_r[1:0], TWO_TAP_IN};
      if (fs_sync_r[1] == fs_sync_r[2]) begin
        fs_lvl_r <= fs_sync_r[2];
      end
      if (tt_sync_r[1] == tt_sync_r[2]) begin
        tt_lvl_r <= tt_sync_r[2];
      end
      fs_prev_r <= fs_lvl_r;
    end
  end
  assign fs_rise = fs_lvl_r & ~fs_prev_r;

  assign last_col = (col_r == `PRS_COLS);
  assign last_pix = last_col && (row_r == `PRS_ROWS);
  assign push     = (state_r == ST_SCAN) && fifo_ready;

  // Scan order: columns left to right, then the next row upward.
  always @* begin
    state_nxt = state_r;
    col_nxt   = col_r;
    row_nxt   = row_r;
    case (state_r)
      ST_IDLE: begin
        if (fs_rise) begin
          state_nxt = ST_SCAN;
          col_nxt   = `PRS_FIRST_COL;
          row_nxt   = `PRS_FIRST_ROW;
        end
      end
      ST_SCAN: begin
        if (push) begin
          if (last_pix) begin
            state_nxt = ST_IDLE;
          end else if (last_col) begin
            col_nxt = `PRS_FIRST_COL;
            row_nxt = row_r + 11'd1;
          end else begin
            col_nxt = col_r + 12'd1;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer state; tap mode is latched at frame start and held for the frame.
  always @(posedge CLOCK_IN or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= ST_IDLE;
      col_r     <= `PRS_FIRST_COL;
      row_r     <= `PRS_FIRST_ROW;
      two_tap_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      col_r   <= col_nxt;
      row_r   <= row_nxt;
      if (state_r == ST_IDLE && fs_rise) begin
        two_tap_r <= tt_lvl_r;
      end
    end
  end

  // Buffer word: frame end, tap, row, three spare zero bits and the pixel value.
  assign wdata = {last_pix, tap_of(col_r, two_tap_r), row_r, 3'b000, PIX_DATA_IN};

  prs_fifo #(
    .WIDTH (`PRS_WORD_W),
    .DEPTH (`PRS_FIFO_DEPTH),
    .AW    (`PRS_FIFO_AW)
  ) u_fifo (
    .clk_in       (CLOCK_IN),
    .rst_b_in     (rst_b),
    .wr_valid_in  (push),
    .wr_ready_out (fifo_ready),
    .wr_data_in   (wdata),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (take),
    .rd_data_out  (rdata)
  );

  // Output stage pops when empty or when its word is accepted.
  assign take = fifo_valid && (!OUT_VALID_OUT || OUT_READY_IN);

  // Column travels in a side register so the buffer word stays compact.
  reg [11:0] col_q_r [0:15];
  reg [3:0]  cwp_r;
  reg [3:0]  crp_r;
  always @(posedge CLOCK_IN or negedge rst_b) begin
    if (!rst_b) begin
      cwp_r <= 4'h0;
      crp_r <= 4'h0;
    end else begin
      if (push) begin
        cwp_r <= cwp_r + 4'h1;
      end
      if (take) begin
        crp_r <= crp_r + 4'h1;
      end
    end
  end
  always @(posedge CLOCK_IN) begin
    if (push) begin
      col_q_r[cwp_r] <= col_r;
    end
  end

  // Registered outputs.
  always @(posedge CLOCK_IN or negedge rst_b) begin
    if (!rst_b) begin
      PIX_COL_OUT       <= `PRS_FIRST_COL;
      PIX_ROW_OUT       <= `PRS_FIRST_ROW;
      OUT_VALID_OUT     <= 1'b0;
      OUT_COL_OUT       <= 12'h000;
      OUT_ROW_OUT       <= 11'h000;
      OUT_TAP_OUT       <= 3'h0;
      OUT_PIX_OUT       <= 10'h000;
      OUT_FRAME_END_OUT <= 1'b0;
      BUSY_OUT          <= 1'b0;
    end else begin
      PIX_COL_OUT <= col_nxt;
      PIX_ROW_OUT <= row_nxt;
      BUSY_OUT    <= (state_nxt == ST_SCAN) || fifo_valid || (OUT_VALID_OUT && !OUT_READY_IN);
      if (take) begin
        OUT_VALID_OUT     <= 1'b1;
        OUT_FRAME_END_OUT <= rdata[`PRS_W_END];
        OUT_TAP_OUT       <= rdata[`PRS_W_TAP_HI:`PRS_W_TAP_LO];
        OUT_ROW_OUT       <= rdata[`PRS_W_ROW_HI:`PRS_W_ROW_LO];
        OUT_PIX_OUT       <= rdata[`PRS_W_PIX_HI:0];
        OUT_COL_OUT       <= col_q_r[crp_r];
      end else if (OUT_READY_IN) begin
        OUT_VALID_OUT <= 1'b0;
      end
    end
  end
endmodule

/* File: prs_sequencer_monitor.sv */
`timescale 1ns/1ps
// Watches the output stream for scan order, tap numbering and the frame end flag.
module prs_sequencer_monitor (
  input wire        CLOCK_IN,          // Clock.
  input wire        RST_B_IN,          // Reset, active low.
  input wire        OUT_VALID_OUT,     // Word valid.
  input wire        OUT_READY_IN,      // Word taken.
  input wire [11:0] OUT_COL_OUT,       // Column.
  input wire [10:0] OUT_ROW_OUT,       // Row.
  input wire [2:0]  OUT_TAP_OUT,       // Tap.
  input wire [9:0]  OUT_PIX_OUT,       // Pixel.
  input wire        OUT_FRAME_END_OUT  // Frame end.
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);
  wire       acc = OUT_VALID_OUT & OUT_READY_IN;
  reg [11:0] lc_r;
  reg [10:0] lr_r;
  reg        seen_r;
  // Keeps the position of the last word taken.
  always @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      seen_r <= 1'b0;
      lc_r   <= 12'h000;
      lr_r   <= 11'h000;
    end else if (acc) begin
      seen_r <= 1'b1;
      lc_r   <= OUT_COL_OUT;
      lr_r   <= OUT_ROW_OUT;
    end
  end
  first_pix_a: assert property (OUT_VALID_OUT & !seen_r |-> OUT_COL_OUT == 12'h001 && OUT_ROW_OUT == 11'h001)
    else $error("first word is not column 1 row 1");
  col_step_a: assert property (acc & seen_r & (lc_r != 12'd2352) |-> OUT_COL_OUT == lc_r + 12'h001 && OUT_ROW_OUT == lr_r)
    else $error("column did not step by one");
  row_step_a: assert property (acc & seen_r & (lc_r == 12'd2352) & (lr_r != 11'd1728)
    |-> OUT_COL_OUT == 12'h001 && OUT_ROW_OUT == lr_r + 11'h001)
    else $error("row did not move up after the last column");
  end_flag_a: assert property (OUT_VALID_OUT |-> OUT_FRAME_END_OUT == (OUT_COL_OUT == 12'd2352 && OUT_ROW_OUT == 11'd1728))
    else $error("frame end flag wrong");
  tap_map_a: assert property (OUT_VALID_OUT |-> OUT_TAP_OUT == {1'b0, OUT_COL_OUT[1:0] - 2'd1} + 3'd1
    || OUT_TAP_OUT == {2'b00, ~OUT_COL_OUT[0]} + 3'd1)
    else $error("tap does not match column");
  word_hold_a: assert property (OUT_VALID_OUT & !OUT_READY_IN |=> OUT_VALID_OUT && $stable(OUT_COL_OUT) && $stable(OUT_PIX_OUT))
    else $error("word changed before it was taken");
  cover property (acc & (lc_r == 12'd2352));
  cover property (OUT_VALID_OUT & !OUT_READY_IN ##1 OUT_VALID_OUT & !OUT_READY_IN);
  cover property (acc & (OUT_TAP_OUT == 3'd2) & (OUT_COL_OUT[1:0] == 2'd0));
endmodule
bind prs_sequencer prs_sequencer_monitor i_mon (.CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN), .OUT_VALID_OUT(OUT_VALID_OUT),
  .OUT_READY_IN(OUT_READY_IN), .OUT_COL_OUT(OUT_COL_OUT), .OUT_ROW_OUT(OUT_ROW_OUT), .OUT_TAP_OUT(OUT_TAP_OUT),
  .OUT_PIX_OUT(OUT_PIX_OUT), .OUT_FRAME_END_OUT(OUT_FRAME_END_OUT));

/* File: prs_grabber.sv */
`timescale 1ns/1ps
// Grabber stand-in that paces its ready line to load the output buffer.
module prs_grabber (
  input  wire       clk_in,           // Clock.
  input  wire [1:0] pace_in,          // 0 always, 1 every other cycle, 2 long stalls.
  output reg        ready_out = 1'b0  // Takes a word.
);
  reg [5:0] cnt_r = 6'h00;
  // Ready moves at the falling edge; a stall of 48 cycles outlasts the buffer.
  always @(negedge clk_in) begin
    cnt_r     <= cnt_r + 6'h01;
    ready_out <= (pace_in == 2'd0) | ((pace_in == 2'd1) & cnt_r[0]) | ((pace_in == 2'd2) & (&cnt_r[5:4]));
  end
endmodule

/* File: prs_sequencer_test.sv */
`timescale 1ns/1ps
// Runs frames through the sequencer and checks every word taken.
module prs_sequencer_test;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         start = 1'b0;
  reg         two = 1'b0;
  reg         et = 1'b0;
  reg  [1:0]  pace = 2'd0;
  reg  [9:0]  pix = 10'h000;
  reg  [11:0] ec = 12'h001;
  reg  [10:0] er = 11'h001;
  integer     n_fail = 0;
  integer     comparisons = 0;
  integer     n_acc = 0;
  wire [11:0] pc, oc;
  wire [10:0] pr, orw;
  wire [2:0]  tap;
  wire [9:0]  op;
  wire        ov, rdy, fe, busy;
  prs_sequencer i_dut (.CLOCK_IN(clk), .RST_B_IN(rst_b), .FRAME_START_IN(start), .TWO_TAP_IN(two), .PIX_DATA_IN(pix),
    .PIX_COL_OUT(pc), .PIX_ROW_OUT(pr), .OUT_VALID_OUT(ov), .OUT_READY_IN(rdy), .OUT_COL_OUT(oc), .OUT_ROW_OUT(orw),
    .OUT_TAP_OUT(tap), .OUT_PIX_OUT(op), .OUT_FRAME_END_OUT(fe), .BUSY_OUT(busy));
  prs_grabber i_fg (.clk_in(clk), .pace_in(pace), .ready_out(rdy));
  // Pixel value made from its site, so a misplaced word shows.
  function [9:0] f(input [11:0] c, input [10:0] r);
    f = c[9:0] ^ {r[4:0], 5'h00};
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Clock of 25 ns period.
  initial forever #12.5 clk = ~clk;
  // Array data follows the address at the falling edge.
  always @(negedge clk) pix <= f(pc, pr);
  // Checks each word taken and steps the expected scan position.
  always @(posedge clk) begin
    if (rst_b && ov === 1'b1 && rdy === 1'b1) begin
      check(oc, ec);
      check(orw, er);
      check(tap, et ? {2'b00, ~ec[0]} + 3'd1 : {1'b0, ec[1:0] - 2'd1} + 3'd1);
      check(op, f(ec, er));
      check(fe, (ec == 12'd2352) && (er == 11'd1728));
      n_acc = n_acc + 1;
      if (ec == 12'd2352) begin
        ec = 12'd1;
        er = er + 11'd1;
      end else begin
        ec = ec + 12'd1;
      end
    end
  end
  // Reset in mid-frame, then release with the address back at 1,1.
  task do_reset;
    rst_b = 1'b0;
    repeat (12) @(negedge clk);
    check(pc, 12'd1);
    check(pr, 11'd1);
    check(ov, 1'b0);
    check(busy, 1'b0);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  // Starts a frame, then toggles the request and tap pins mid-frame, which must change nothing.
  task frame(input m, input [1:0] p, input integer n);
    integer k;
    two = m;
    et = m;
    pace = p;
    ec = 12'd1;
    er = 11'd1;
    n_acc = 0;
    start = 1'b1;
    for (k = 0; k < 50 * n && n_acc < n; k = k + 1) begin
      @(negedge clk);
      if (n_acc > 8) begin
        start = k[1];
        two = k[2];
      end
    end
    check(n_acc, n);
    start = 1'b0;
  endtask
  // Four taps, ready held: row one wraps into row two back to back.
  task t_four;
    frame(1'b0, 2'd0, 2360);
    check(er, 11'd2);
    do_reset;
  endtask
  // Two taps with ready every other cycle.
  task t_two;
    frame(1'b1, 2'd1, 40);
    do_reset;
  endtask
  // Long stalls fill the buffer; the scan waits and skips nothing.
  task t_stall;
    frame(1'b0, 2'd2, 64);
    check(busy, 1'b1);
    do_reset;
  endtask
  // Cuts a hung run short.
  initial begin
    #500000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
  // Main sequence.
  initial begin
    do_reset;
    t_four;
    t_two;
    t_stall;
    report_and_stop;
  end
endmodule
